// File: src/gtb_timer.sv
// General timer block, 32-bit one-shot/periodic and real-time clock modes.
// Assumes an Avalon-MM master on clk_in and an external 32.768 kHz clock on the even pin.
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`include "gtb_cfg.svh"

module gtb_timer (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Debug and system
  input  wire logic        cpu_halted_in,
  output logic             timer_irq_out,
  output logic             converter_trigger_out,
  // Even capture pin, used as real-time clock input
  input  wire logic        even_pin_in,
  input  wire logic        even_pin_function_in
);

  // ==========================================================
  // Registers
  logic [2:0]  cfg_r;
  logic [1:0]  amode_r;
  logic [1:0]  bmode_r;
  logic        aen_r;
  logic        astall_r;
  logic        bstall_r;
  logic        clock_mode_enable_bit_r;
  logic        aote_r;
  logic [3:0]  imr_r;
  logic [3:0]  ris_r;
  logic [15:0] ailr_r;
  logic [15:0] bilr_r;
  logic [31:0] amatch_r;
  logic [7:0]  apre_r;
  logic [7:0]  bpre_r;
  logic [15:0] acnt_r;
  logic [15:0] bcnt_r;
  logic        rtc_loaded_r;
  logic        reload_req_r;
  logic        halt_s1_r;
  logic        halt_s2_r;
  logic        pinsel_s1_r;
  logic        pinsel_s2_r;
  gtb_pkg::gtb_state_t state_r;

  logic        wr_go;
  logic        rd_go;
  logic        rtc_tick;
  logic        timeout;
  logic        match;
  logic        frozen;
  logic        wr_ctl;
  logic [31:0] count;
  logic [3:0]  ris_nxt;
  logic [3:0]  icr_mask;

  assign count = {bcnt_r, acnt_r};

  // ==========================================================
  // Bus handshake: one wait cycle per access, then accept
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
      avs_waitrequest_out <= 1'b0;
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  assign wr_go  = avs_write_in && !avs_waitrequest_out;
  assign rd_go  = avs_read_in && !avs_waitrequest_out;
  assign wr_ctl = wr_go && avs_address_in == `GTB_OFF_CTL && avs_byteenable_in[0];

  // ==========================================================
  // Debug halt and pin select synchronisers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      halt_s1_r   <= 1'b0;
      halt_s2_r   <= 1'b0;
      pinsel_s1_r <= 1'b0;
      pinsel_s2_r <= 1'b0;
    end else begin
      halt_s1_r   <= cpu_halted_in;
      halt_s2_r   <= halt_s1_r;
      pinsel_s1_r <= even_pin_function_in;
      pinsel_s2_r <= pinsel_s1_r;
    end
  end

  // ==========================================================
  // Real-time input: synchronised and divided, only when the pin is selected
  gtb_sync_div u_sync_div (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .run_in      (state_r == gtb_pkg::GTB_RTC && pinsel_s2_r),
    .slow_clk_in (even_pin_in),
    .tick_out    (rtc_tick)
  );

  // Stall applies in down mode only; clock mode runs through halt
  assign frozen  = halt_s2_r && astall_r && !clock_mode_enable_bit_r;
  // Enable gates the time-out too, so a stopped one-shot cannot fire again on a zero load
  assign timeout = state_r == gtb_pkg::GTB_DOWN && aen_r && !frozen && count == 32'h00000000;
  assign match   = state_r == gtb_pkg::GTB_RTC && rtc_tick && count == amatch_r;

  // ==========================================================
  // Configuration and mode registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_r   <= 3'h0;
      amode_r <= 2'h0;
      bmode_r <= 2'h0;
      imr_r   <= 4'h0;
    end else if (wr_go && avs_byteenable_in[0]) begin
      case (avs_address_in)
        `GTB_OFF_CFG:   cfg_r   <= avs_writedata_in[2:0];
        `GTB_OFF_AMODE: amode_r <= avs_writedata_in[1:0];
        `GTB_OFF_BMODE: bmode_r <= avs_writedata_in[1:0];
        `GTB_OFF_IMR:   imr_r   <= avs_writedata_in[3:0];
        default:        ;
      endcase
    end
  end

  // ==========================================================
  // Control register; hardware clears enable at a one-shot time-out
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aen_r    <= 1'b0;
      astall_r <= 1'b0;
      bstall_r <= 1'b0;
      clock_mode_enable_bit_r  <= 1'b0;
      aote_r   <= 1'b0;
    end else begin
      if (wr_ctl) begin
        aen_r    <= avs_writedata_in[`GTB_CTL_AEN];
        astall_r <= avs_writedata_in[`GTB_CTL_ASTALL];
        clock_mode_enable_bit_r  <= avs_writedata_in[`GTB_CTL_CLOCK_MODE_ENABLE_BIT];
        aote_r   <= avs_writedata_in[`GTB_CTL_AOTE];
        if (avs_byteenable_in[1]) begin
          bstall_r <= avs_writedata_in[`GTB_CTL_BSTALL];
        end
      end
      if (timeout && amode_r == `GTB_MODE_ONESHOT) begin
        aen_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Load, match and prescale registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ailr_r   <= `GTB_HALF_RST;
      bilr_r   <= `GTB_HALF_RST;
      amatch_r <= 32'hFFFFFFFF;
      apre_r   <= `GTB_PRE_RST;
      bpre_r   <= `GTB_PRE_RST;
    end else if (wr_go) begin
      case (avs_address_in)
        `GTB_OFF_AILR: begin
          ailr_r <= avs_writedata_in[15:0];
          if (cfg_r == `GTB_CFG_32 || cfg_r == `GTB_CFG_RTC) begin
            bilr_r <= avs_writedata_in[31:16];
          end
        end
        `GTB_OFF_BILR:   bilr_r   <= avs_writedata_in[15:0];
        `GTB_OFF_AMATCH: amatch_r <= avs_writedata_in;
        `GTB_OFF_APRE:   apre_r   <= avs_writedata_in[7:0];
        `GTB_OFF_BPRE:   bpre_r   <= avs_writedata_in[7:0];
        default:         ;
      endcase
    end
  end

  // ==========================================================
  // In 32-bit configuration an AILR write reaches the counter on the next cycle, running or not, so enable starts from it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reload_req_r <= 1'b0;
    end else begin
      reload_req_r <= wr_go && avs_address_in == `GTB_OFF_AILR && cfg_r == `GTB_CFG_32;
    end
  end

  // ==========================================================
  // Operating state follows configuration and enable
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= gtb_pkg::GTB_IDLE;
    end else begin
      case (cfg_r)
        `GTB_CFG_32:  state_r <= aen_r ? gtb_pkg::GTB_DOWN : gtb_pkg::GTB_IDLE;
        `GTB_CFG_RTC: state_r <= aen_r ? gtb_pkg::GTB_RTC : gtb_pkg::GTB_IDLE;
        default:      state_r <= gtb_pkg::GTB_IDLE;
      endcase
    end
  end

  // ==========================================================
  // The 32-bit counter formed from both halves
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      {bcnt_r, acnt_r} <= {`GTB_HALF_RST, `GTB_HALF_RST};
      rtc_loaded_r     <= 1'b0;
    end else begin
      if (cfg_r != `GTB_CFG_RTC) begin
        rtc_loaded_r <= 1'b0;
      end
      if (cfg_r == `GTB_CFG_RTC && !rtc_loaded_r) begin
        {bcnt_r, acnt_r} <= `GTB_RTC_FIRST;
        rtc_loaded_r     <= 1'b1;
      end else if (reload_req_r) begin
        {bcnt_r, acnt_r} <= {bilr_r, ailr_r};
      end else if (timeout) begin
        {bcnt_r, acnt_r} <= {bilr_r, ailr_r};
      end else if (state_r == gtb_pkg::GTB_DOWN && aen_r && !frozen) begin
        {bcnt_r, acnt_r} <= count - 32'h00000001;
      end else if (match) begin
        {bcnt_r, acnt_r} <= 32'h00000000;
      end else if (state_r == gtb_pkg::GTB_RTC && rtc_tick) begin
        {bcnt_r, acnt_r} <= count + 32'h00000001;
      end
    end
  end

  // ==========================================================
  // Raw status: set wins over a same-cycle clear
  always_comb begin
    icr_mask = 4'h0;
    if (wr_go && avs_address_in == `GTB_OFF_ICR) begin
      icr_mask = avs_writedata_in[3:0];
    end
    ris_nxt = ris_r & ~icr_mask;
    if (timeout) begin
      ris_nxt[`GTB_INT_ATO] = 1'b1;
    end
    if (match) begin
      ris_nxt[`GTB_INT_RTC] = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ris_r <= 4'h0;
    end else begin
      ris_r <= ris_nxt;
    end
  end

  // ==========================================================
  // Interrupt and converter trigger outputs
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      timer_irq_out         <= 1'b0;
      converter_trigger_out <= 1'b0;
    end else begin
      timer_irq_out         <= |(ris_nxt & imr_r);
      converter_trigger_out <= timeout && aote_r;
    end
  end

  // ==========================================================
  // Read data, registered during the wait cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in && avs_waitrequest_out) begin
      case (avs_address_in)
        `GTB_OFF_CFG:    avs_readdata_out <= {29'h0, cfg_r};
        `GTB_OFF_AMODE:  avs_readdata_out <= {30'h0, amode_r};
        `GTB_OFF_BMODE:  avs_readdata_out <= {30'h0, bmode_r};
        `GTB_OFF_CTL:    avs_readdata_out <= {22'h0, bstall_r, 3'h0, aote_r, clock_mode_enable_bit_r, 2'h0, astall_r, aen_r};
        `GTB_OFF_IMR:    avs_readdata_out <= {28'h0, imr_r};
        `GTB_OFF_RIS:    avs_readdata_out <= {28'h0, ris_r};
        `GTB_OFF_MIS:    avs_readdata_out <= {28'h0, ris_r & imr_r};
        `GTB_OFF_AILR:   avs_readdata_out <= (cfg_r <= `GTB_CFG_RTC) ? {bilr_r, ailr_r} : {16'h0, ailr_r};
        `GTB_OFF_BILR:   avs_readdata_out <= {16'h0, bilr_r};
        `GTB_OFF_AMATCH: avs_readdata_out <= amatch_r;
        `GTB_OFF_APRE:   avs_readdata_out <= {24'h0, apre_r};
        `GTB_OFF_BPRE:   avs_readdata_out <= {24'h0, bpre_r};
        `GTB_OFF_AVAL:   avs_readdata_out <= (cfg_r <= `GTB_CFG_RTC) ? count : {16'h0, acnt_r};
        `GTB_OFF_BVAL:   avs_readdata_out <= {16'h0, bcnt_r};
        `GTB_OFF_DBG:    avs_readdata_out <= {31'h0, pinsel_s2_r};
        default:         avs_readdata_out <= 32'h00000000;
      endcase
    end
  end

  // Unused read qualifier kept for clarity of bus decode
  logic unused_rd;
  assign unused_rd = rd_go;

endmodule : gtb_timer

// File: src/gtb_cfg.svh
// Constants for the general timer block: register offsets, field positions, reset values, timing.
// Assumes a 32-bit Avalon-MM slave with word addresses given as byte offsets.
`ifndef GTB_CFG_SVH
`define GTB_CFG_SVH

// ==========================================================
// Register byte offsets
`define GTB_OFF_CFG      8'h00
`define GTB_OFF_AMODE    8'h04
`define GTB_OFF_BMODE    8'h08
`define GTB_OFF_CTL      8'h0C
`define GTB_OFF_IMR      8'h18
`define GTB_OFF_RIS      8'h1C
`define GTB_OFF_MIS      8'h20
`define GTB_OFF_ICR      8'h24
`define GTB_OFF_AILR     8'h28
`define GTB_OFF_BILR     8'h2C
`define GTB_OFF_AMATCH   8'h30
`define GTB_OFF_APRE     8'h38
`define GTB_OFF_BPRE     8'h3C
`define GTB_OFF_AVAL     8'h48
`define GTB_OFF_BVAL     8'h4C
`define GTB_OFF_DBG      8'h50

// ==========================================================
// Field positions
`define GTB_CTL_AEN      0
`define GTB_CTL_ASTALL   1
`define GTB_CTL_CLOCK_MODE_ENABLE_BIT    4
`define GTB_CTL_AOTE     5
`define GTB_CTL_BSTALL   9
`define GTB_INT_ATO      0
`define GTB_INT_RTC      3

// ==========================================================
// Reset values and constants
`define GTB_HALF_RST     16'hFFFF
`define GTB_PRE_RST      8'h00
`define GTB_RTC_FIRST    32'h00000001
`define GTB_MODE_ONESHOT 2'h1
`define GTB_MODE_PERIOD  2'h2
`define GTB_CFG_32       3'h0
`define GTB_CFG_RTC      3'h1
`define GTB_RTC_IN_HZ    32768
`define GTB_RTC_OUT_HZ   1
`define GTB_RTC_DIV      (`GTB_RTC_IN_HZ / `GTB_RTC_OUT_HZ)

`endif

// File: src/gtb_pkg.sv
// Types shared by the general timer block.
// Assumes gtb_cfg.svh carries the numeric constants.
package gtb_pkg;

  // ==========================================================
  // Operating state of the 32-bit counter
  typedef enum logic [1:0] {
    GTB_IDLE = 2'b00,
    GTB_DOWN = 2'b01,
    GTB_RTC  = 2'b10
  } gtb_state_t;

endpackage : gtb_pkg

// File: src/gtb_sync_div.sv
// Synchroniser and divider for the slow real-time input clock.
// Assumes the input is asynchronous and much slower than clk_in.
`include "gtb_cfg.svh"

module gtb_sync_div (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Control
  input  wire logic run_in,
  // Slow clock and output tick
  input  wire logic slow_clk_in,
  output logic      tick_out
);

  logic        s1_r;
  logic        s2_r;
  logic        s3_r;
  logic [14:0] cnt_r;

  // ==========================================================
  // Two-flop synchroniser, then edge detect on the second stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= slow_clk_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ==========================================================
  // Count rising edges, one tick per full second
  always_ff @(posedge clk_in) begin
    if (rst_in || !run_in) begin
      cnt_r    <= 15'h0000;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (s2_r && !s3_r) begin
        if (cnt_r == 15'(`GTB_RTC_DIV - 1)) begin
          cnt_r    <= 15'h0000;
          tick_out <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 15'h0001;
        end
      end
    end
  end

endmodule : gtb_sync_div

// File: verification/gtb_rtc_src.sv
// Model of the external slow clock source on the even capture pin.
// Assumes the bench starts and stops bursts; the pin stands low outside a burst.
module gtb_rtc_src (
  // System clock paces the edges
  input  wire logic clk_in,
  // Burst control
  input  wire logic run_in,
  // Slow clock onto the even pin
  output logic      pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Half period in system cycles; one toggle per cycle keeps a full 1 Hz tick near 65536 cycles
  localparam int HALF = 1;
  int cnt = 0;
  initial pin_out = 1'b0;
  // ==========================================================
  // Toggle while a burst runs, otherwise stand still low
  always @(posedge clk_in) begin
    if (!run_in) begin
      pin_out <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      pin_out <= ~pin_out;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : gtb_rtc_src

// File: verification/gtb_chk.sv
// Checker for the general timer block: bus handshake, reset, trigger and interrupt.
// Assumes it is bound to gtb_timer and sees only its ports.
`include "gtb_cfg.svh"
module gtb_chk (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // Bus
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // Events
  input wire logic        timer_irq_out,
  input wire logic        converter_trigger_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ote_r;
  logic take_w;
  logic clr_w;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================================
  // Taken writes and shadow of the trigger enable
  assign take_w = avs_write_in && !avs_waitrequest_out;
  assign clr_w = take_w && (avs_address_in == `GTB_OFF_ICR || avs_address_in == `GTB_OFF_IMR);
  always_ff @(posedge clk_in) begin
    if (rst_in)
      ote_r <= 1'b0;
    else if (take_w && avs_address_in == `GTB_OFF_CTL && avs_byteenable_in[0])
      ote_r <= avs_writedata_in[`GTB_CTL_AOTE];
  end
  // ==========================================================
  // Handshake sequences
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_answer;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  property p_wait_one;
    s_req |=> s_answer;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state not exactly one cycle");
  property p_idle;
    !(avs_read_in || avs_write_in) |=> avs_waitrequest_out;
  endproperty
  a_idle: assert property (p_idle) else $error("waitrequest low without request");
  property p_rst;
    disable iff (1'b0)
    rst_in |=> avs_waitrequest_out && !timer_irq_out && !converter_trigger_out && avs_readdata_out == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not in reset state");
  property p_trig_one;
    converter_trigger_out |=> !converter_trigger_out;
  endproperty
  a_trig_one: assert property (p_trig_one) else $error("trigger longer than one cycle");
  property p_trig_ote;
    converter_trigger_out |-> ote_r || $past(ote_r) || $past(ote_r, 2);
  endproperty
  a_trig_ote: assert property (p_trig_ote) else $error("trigger with trigger enable clear");
  property p_irq_fall;
    $fell(timer_irq_out) |-> $past(clr_w) || $past(clr_w, 2) || $past(rst_in);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without clear");
  property p_rd_stands;
    $changed(avs_readdata_out) |-> (avs_read_in && !avs_waitrequest_out) || $past(rst_in);
  endproperty
  a_rd_stands: assert property (p_rd_stands) else $error("read data changed outside a read");
  property p_rd_zero;
    avs_read_in && !avs_waitrequest_out && (avs_address_in == `GTB_OFF_ICR || avs_address_in == 8'h44)
      |-> avs_readdata_out == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("clear or unmapped read not zero");
endmodule : gtb_chk

bind gtb_timer gtb_chk gtb_chk_inst (.*);

// File: verification/tb_top.sv
// Self-checking bench for the general timer block over its register bus.
// Assumes gtb_timer, gtb_chk and gtb_rtc_src are compiled before it.
`include "gtb_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic        halt = 1'b0;
  logic        pin_sel = 1'b0;
  logic        rtc_run = 1'b0;
  logic [31:0] rdata;
  logic        wait_q;
  logic        irq;
  logic        trig;
  logic        pin;
  int          err_count = 0;
  int          checked = 0;
  int          trig_cnt = 0;
  // ==========================================================
  // Design and slow clock model
  gtb_timer gtb_timer_inst (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_q), .cpu_halted_in(halt), .timer_irq_out(irq),
    .converter_trigger_out(trig), .even_pin_in(pin), .even_pin_function_in(pin_sel));
  gtb_rtc_src gtb_rtc_src_inst (.clk_in(clk_in), .run_in(rtc_run), .pin_out(pin));
  // Clock and trigger pulse count
  initial forever #10 clk_in = ~clk_in;
  always @(posedge clk_in) if (trig === 1'b1) trig_cnt++;
  // ==========================================================
  // Compare and bus tasks
  task automatic cmp32(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp32
  task automatic cmp1(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask : cmp1
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    addr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    @(posedge clk_in);
    while (wait_q !== 1'b0) @(posedge clk_in);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr32
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp32(name, exp, q & m);
  endtask : rdchk
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rdchk("cfg", `GTB_OFF_CFG, 32'h0, 32'hFFFFFFFF);
    rdchk("ctl", `GTB_OFF_CTL, 32'h0, 32'hFFFFFFFF);
    rdchk("imr", `GTB_OFF_IMR, 32'h0, 32'hFFFFFFFF);
    rdchk("ris", `GTB_OFF_RIS, 32'h0, 32'hFFFFFFFF);
    rdchk("aload", `GTB_OFF_AILR, 32'h0000FFFF, 32'h0000FFFF);
    rdchk("bload", `GTB_OFF_BILR, 32'h0000FFFF, 32'h0000FFFF);
    rdchk("count", `GTB_OFF_AVAL, 32'hFFFFFFFF, 32'hFFFFFFFF);
    rdchk("apre", `GTB_OFF_APRE, 32'h0, 32'hFFFFFFFF);
    rdchk("bpre", `GTB_OFF_BPRE, 32'h0, 32'hFFFFFFFF);
    rdchk("unmapped", 8'h44, 32'h0, 32'hFFFFFFFF);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_concat;
    wr32(`GTB_OFF_AILR, 32'h00030002);
    rdchk("bload hi", `GTB_OFF_BILR, 32'h00000003, 32'h0000FFFF);
    rdchk("aload lo", `GTB_OFF_AILR, 32'h00000002, 32'h0000FFFF);
    $display("t_concat done");
  endtask : t_concat
  task automatic t_oneshot;
    int n;
    wr32(`GTB_OFF_IMR, 32'h1);
    wr32(`GTB_OFF_AILR, 32'h0000000A);
    wr32(`GTB_OFF_AMODE, {30'h0, `GTB_MODE_ONESHOT});
    wr32(`GTB_OFF_BMODE, {30'h0, `GTB_MODE_PERIOD});
    n = trig_cnt;
    wr32(`GTB_OFF_CTL, 32'h21);
    repeat (60) @(posedge clk_in);
    cmp32("one pulse", n + 1, trig_cnt);
    rdchk("ctl stop", `GTB_OFF_CTL, 32'h20, 32'hFFFFFFFF);
    rdchk("ris set", `GTB_OFF_RIS, 32'h1, 32'hFFFFFFFF);
    rdchk("mis set", `GTB_OFF_MIS, 32'h1, 32'hFFFFFFFF);
    cmp1("irq set", 1'b1, irq);
    rdchk("reloaded", `GTB_OFF_AVAL, 32'h0000000A, 32'hFFFFFFFF);
    wr32(`GTB_OFF_ICR, 32'h1);
    rdchk("ris clr", `GTB_OFF_RIS, 32'h0, 32'hFFFFFFFF);
    cmp1("irq clr", 1'b0, irq);
    $display("t_oneshot done");
  endtask : t_oneshot
  task automatic t_periodic;
    int n;
    logic [31:0] q;
    logic [31:0] q2;
    wr32(`GTB_OFF_IMR, 32'h0);
    wr32(`GTB_OFF_AILR, 32'h00000004);
    wr32(`GTB_OFF_AMODE, {30'h0, `GTB_MODE_PERIOD});
    n = trig_cnt;
    wr32(`GTB_OFF_CTL, 32'h1);
    repeat (40) @(posedge clk_in);
    cmp32("no pulse", n, trig_cnt);
    rdchk("ctl run", `GTB_OFF_CTL, 32'h1, 32'hFFFFFFFF);
    rdchk("ris per", `GTB_OFF_RIS, 32'h1, 32'hFFFFFFFF);
    rdchk("mis per", `GTB_OFF_MIS, 32'h0, 32'hFFFFFFFF);
    cmp1("irq masked", 1'b0, irq);
    wr32(`GTB_OFF_AILR, 32'h00010000);
    bus(1'b0, `GTB_OFF_AVAL, 32'h0, q);
    cmp1("new load", 1'b1, q <= 32'h00010000 && q > 32'h0000FF00);
    @(posedge clk_in);
    halt <= 1'b1;
    wr32(`GTB_OFF_CTL, 32'h3);
    repeat (4) @(posedge clk_in);
    bus(1'b0, `GTB_OFF_AVAL, 32'h0, q);
    bus(1'b0, `GTB_OFF_AVAL, 32'h0, q2);
    cmp32("stalled", q, q2);
    halt <= 1'b0;
    repeat (4) @(posedge clk_in);
    bus(1'b0, `GTB_OFF_AVAL, 32'h0, q2);
    cmp1("resumed", 1'b1, q2 < q);
    wr32(`GTB_OFF_CTL, 32'h0);
    wr32(`GTB_OFF_ICR, 32'hFFFFFFFF);
    $display("t_periodic done");
  endtask : t_periodic
  task automatic t_rtc;
    wr32(`GTB_OFF_CFG, {29'h0, `GTB_CFG_RTC});
    wr32(`GTB_OFF_AMATCH, 32'h1);
    wr32(`GTB_OFF_IMR, 32'h8);
    @(posedge clk_in);
    halt <= 1'b1;
    pin_sel <= 1'b1;
    wr32(`GTB_OFF_CTL, 32'h213);
    rdchk("rtc first", `GTB_OFF_AVAL, `GTB_RTC_FIRST, 32'hFFFFFFFF);
    rtc_run <= 1'b1;
    repeat (300) @(posedge clk_in);
    rdchk("rtc divided", `GTB_OFF_AVAL, `GTB_RTC_FIRST, 32'hFFFFFFFF);
    rdchk("rtc no match", `GTB_OFF_RIS, 32'h0, 32'hFFFFFFFF);
    cmp1("rtc irq", 1'b0, irq);
    // First 1 Hz tick meets the match value while halted with both stalls set
    for (int i = 0; i < 70000 && irq !== 1'b1; i++) @(posedge clk_in);
    cmp1("rtc irq set", 1'b1, irq);
    rdchk("rtc rolled", `GTB_OFF_AVAL, 32'h0, 32'hFFFFFFFF);
    rdchk("rtc raw", `GTB_OFF_RIS, 32'h8, 32'hFFFFFFFF);
    rdchk("rtc masked", `GTB_OFF_MIS, 32'h8, 32'hFFFFFFFF);
    wr32(`GTB_OFF_ICR, 32'h8);
    rdchk("rtc raw clr", `GTB_OFF_RIS, 32'h0, 32'hFFFFFFFF);
    rdchk("rtc masked clr", `GTB_OFF_MIS, 32'h0, 32'hFFFFFFFF);
    cmp1("rtc irq clr", 1'b0, irq);
    rtc_run <= 1'b0;
    wr32(`GTB_OFF_CTL, 32'h0);
    $display("t_rtc done");
  endtask : t_rtc
  // ==========================================================
  // Verdict and run control
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset;
    t_concat;
    t_oneshot;
    t_periodic;
    t_rtc;
    end_of_test;
  end
  // Watchdog beyond the expected run of about 66000 cycles, one real-time tick included
  initial begin
    #1600000;
    err_count++;
    end_of_test;
  end
endmodule : tb_top
